// ### inc/cavr_defs.svh
// Register offsets, reset values and field positions for the counter array value registers
// Behaviour
// - High byte reads snapshot taken on low read
// - Watchdog enabled blocks counter high writes
// - Low address selects value or reload low
// - High address selects value or reload high
// - Value low write clears comparator enable
// - Value high write sets comparator enable
// - Byte registers readable, writable, reset zero
// - Watchdog enabled blocks counter low writes
// - Comparator enable gates compare function
`ifndef CAVR_DEFS_SVH
`define CAVR_DEFS_SVH
`define CAVR_ADDR_CNT_LOW 8'hf9
`define CAVR_ADDR_CNT_HIGH 8'hfa
`define CAVR_ADDR_M0_LOW 8'hfb
`define CAVR_ADDR_M0_HIGH 8'hfc
`define CAVR_ADDR_M1_LOW 8'he9
`define CAVR_ADDR_M1_HIGH 8'hea
`define CAVR_ADDR_M2_LOW 8'heb
`define CAVR_ADDR_M2_HIGH 8'hec
`define CAVR_ADDR_CTRL 8'he0
`define CAVR_BYTE_RESET 8'h00
`define CAVR_CTRL_RESET 8'h00
`define CAVR_CTRL_RSEL_BIT 0
`define CAVR_CTRL_WDOG_BIT 1
`define CAVR_CTRL_RUN_BIT 2
`define CAVR_CTRL_ECOM0_BIT 4
`define CAVR_CTRL_ECOM_W 3
`define CAVR_NUM_MOD 3
`endif

// ### inc/cavr_pkg.sv
// Types shared by the counter array value register files
package cavr_pkg;
    // One register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cavr_req_t;
    // Decoded register target
    typedef enum logic [2:0] {
        CAVR_T_NONE = 3'b000,
        CAVR_T_CNT_LOW = 3'b001,
        CAVR_T_CNT_HIGH = 3'b010,
        CAVR_T_MOD_LOW = 3'b011,
        CAVR_T_MOD_HIGH = 3'b100,
        CAVR_T_CTRL = 3'b101
    } cavr_target_t;
endpackage

// ### rtl/cavr_counter.sv
// Sixteen-bit counter with byte writes and a high-byte read snapshot
`include "cavr_defs.svh"
module cavr_counter
    import cavr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    input wire logic wdog_en,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic rd_low,
    input wire logic [7:0] wdata,
    output logic [15:0] count,
    output logic [7:0] snap_high
);
    logic [15:0] count_q; // Running count
    logic [7:0] snap_q; // Captured high byte
    // Count, with software byte writes locked while the watchdog owns the counter
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= {`CAVR_BYTE_RESET, `CAVR_BYTE_RESET};
        end else if (wr_low && !wdog_en) begin
            count_q <= {count_q[15:8], wdata};
        end else if (wr_high && !wdog_en) begin
            count_q <= {wdata, count_q[7:0]};
        end else if (run) begin
            count_q <= count_q + 16'h0001;
        end
    end
    // Snapshot keeps a 16-bit read coherent across two byte reads
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            snap_q <= `CAVR_BYTE_RESET;
        end else if (rd_low) begin
            snap_q <= count_q[15:8];
        end
    end
    assign count = count_q;
    assign snap_high = snap_q;
endmodule // cavr_counter

// ### rtl/cavr_module.sv
// One capture/compare module: value, auto-reload value and comparator enable
`include "cavr_defs.svh"
module cavr_module
    import cavr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic reload_sel,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    input wire logic [15:0] count,
    output logic [7:0] rd_low,
    output logic [7:0] rd_high,
    output logic [15:0] value,
    output logic ecom,
    output logic match
);
    logic [15:0] value_q; // Capture/compare value
    logic [15:0] reload_q; // PWM auto-reload value
    logic ecom_q; // Comparator enable
    // Byte writes land in the value or the reload copy
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            value_q <= {`CAVR_BYTE_RESET, `CAVR_BYTE_RESET};
            reload_q <= {`CAVR_BYTE_RESET, `CAVR_BYTE_RESET};
        end else if (wr_low) begin
            if (reload_sel) begin
                reload_q[7:0] <= wdata;
            end else begin
                value_q[7:0] <= wdata;
            end
        end else if (wr_high) begin
            if (reload_sel) begin
                reload_q[15:8] <= wdata;
            end else begin
                value_q[15:8] <= wdata;
            end
        end
    end
    // Any write to either byte address moves the enable, whichever copy is selected
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ecom_q <= 1'b0;
        end else if (wr_low) begin
            ecom_q <= 1'b0;
        end else if (wr_high) begin
            ecom_q <= 1'b1;
        end
    end
    assign rd_low = reload_sel ? reload_q[7:0] : value_q[7:0];
    assign rd_high = reload_sel ? reload_q[15:8] : value_q[15:8];
    assign value = value_q;
    assign ecom = ecom_q;
    assign match = ecom_q && (count == value_q);
endmodule // cavr_module

// ### rtl/cavr_regs.sv
// Register access logic for the counter array value registers
//
// The address-and-strobe port was decided locally.
`include "cavr_defs.svh"
module cavr_regs
    import cavr_pkg::*;
#(
    parameter int NUM_MOD = `CAVR_NUM_MOD
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic [NUM_MOD-1:0] comparator_enable,
    output logic [NUM_MOD-1:0] match,
    output logic [15:0] counter_value
);
    cavr_req_t req; // Bundled bus request
    logic [7:0] ctrl_q; // Control: reload select, watchdog enable, run
    logic [7:0] rdata_q; // Read data register
    logic [NUM_MOD-1:0] match_q; // Registered match outputs
    logic [NUM_MOD-1:0] ecom_q; // Registered enables
    logic [15:0] cnt_out_q; // Registered counter
    logic [15:0] count; // Live counter
    logic [7:0] snap_high; // Snapshot byte
    logic [NUM_MOD-1:0] m_wr_low; // Per-module low write strobes
    logic [NUM_MOD-1:0] m_wr_high; // Per-module high write strobes
    logic [NUM_MOD-1:0] m_ecom; // Module enables
    logic [NUM_MOD-1:0] m_match; // Module matches
    logic [7:0] m_rd_low [NUM_MOD]; // Module low read bytes
    logic [7:0] m_rd_high [NUM_MOD]; // Module high read bytes
    cavr_target_t tgt; // Decoded target
    logic [1:0] tgt_mod; // Module index of decoded target

    assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

    // Map an address to a target kind; used for both reads and writes
    function automatic cavr_target_t cavr_decode(input logic [7:0] a);
        case (a)
            `CAVR_ADDR_CNT_LOW: cavr_decode = CAVR_T_CNT_LOW;
            `CAVR_ADDR_CNT_HIGH: cavr_decode = CAVR_T_CNT_HIGH;
            `CAVR_ADDR_M0_LOW, `CAVR_ADDR_M1_LOW, `CAVR_ADDR_M2_LOW: cavr_decode = CAVR_T_MOD_LOW;
            `CAVR_ADDR_M0_HIGH, `CAVR_ADDR_M1_HIGH, `CAVR_ADDR_M2_HIGH: cavr_decode = CAVR_T_MOD_HIGH;
            `CAVR_ADDR_CTRL: cavr_decode = CAVR_T_CTRL;
            default: cavr_decode = CAVR_T_NONE;
        endcase
    endfunction

    // Module index of a capture/compare address
    function automatic logic [1:0] cavr_mod_index(input logic [7:0] a);
        case (a)
            `CAVR_ADDR_M1_LOW, `CAVR_ADDR_M1_HIGH: cavr_mod_index = 2'h1;
            `CAVR_ADDR_M2_LOW, `CAVR_ADDR_M2_HIGH: cavr_mod_index = 2'h2;
            default: cavr_mod_index = 2'h0;
        endcase
    endfunction

    assign tgt = cavr_decode(req.addr);
    assign tgt_mod = cavr_mod_index(req.addr);

    // Control register; its bits stand in for the mode bits held elsewhere in the array
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= `CAVR_CTRL_RESET;
        end else if (req.wr && tgt == CAVR_T_CTRL) begin
            ctrl_q <= req.wdata;
        end
    end

    // Counter and snapshot
    cavr_counter u_counter (
        .clock(clock),
        .reset(reset),
        .run(ctrl_q[`CAVR_CTRL_RUN_BIT]),
        .wdog_en(ctrl_q[`CAVR_CTRL_WDOG_BIT]),
        .wr_low(req.wr && tgt == CAVR_T_CNT_LOW),
        .wr_high(req.wr && tgt == CAVR_T_CNT_HIGH),
        .rd_low(req.rd && tgt == CAVR_T_CNT_LOW),
        .wdata(req.wdata),
        .count(count),
        .snap_high(snap_high)
    );

    // Capture/compare modules, one per index
    for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
        assign m_wr_low[i] = req.wr && tgt == CAVR_T_MOD_LOW && tgt_mod == 2'(i);
        assign m_wr_high[i] = req.wr && tgt == CAVR_T_MOD_HIGH && tgt_mod == 2'(i);
        cavr_module u_mod (
            .clock(clock),
            .reset(reset),
            .reload_sel(ctrl_q[`CAVR_CTRL_RSEL_BIT]),
            .wr_low(m_wr_low[i]),
            .wr_high(m_wr_high[i]),
            .wdata(req.wdata),
            .count(count),
            .rd_low(m_rd_low[i]),
            .rd_high(m_rd_high[i]),
            .value(),
            .ecom(m_ecom[i]),
            .match(m_match[i])
        );
    end

    // Read data valid the cycle after the strobe only; zero otherwise
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= `CAVR_BYTE_RESET;
        end else if (req.rd) begin
            case (tgt)
                CAVR_T_CNT_LOW: rdata_q <= count[7:0];
                CAVR_T_CNT_HIGH: rdata_q <= snap_high;
                CAVR_T_MOD_LOW: rdata_q <= m_rd_low[tgt_mod];
                CAVR_T_MOD_HIGH: rdata_q <= m_rd_high[tgt_mod];
                // Enables shown read-only in the upper bits
                CAVR_T_CTRL: rdata_q <= {1'b0, m_ecom, ctrl_q[3:0]};
                // Unmapped addresses read zero
                default: rdata_q <= `CAVR_BYTE_RESET;
            endcase
        end else begin
            rdata_q <= `CAVR_BYTE_RESET;
        end
    end

    // Registered outputs so nothing combinational leaves the block
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            match_q <= '0;
            ecom_q <= '0;
            cnt_out_q <= {`CAVR_BYTE_RESET, `CAVR_BYTE_RESET};
        end else begin
            match_q <= m_match;
            ecom_q <= m_ecom;
            cnt_out_q <= count;
        end
    end

    assign rdata = rdata_q;
    assign comparator_enable = ecom_q;
    assign match = match_q;
    assign counter_value = cnt_out_q;
endmodule // cavr_regs

// ### verification/cavr_regs_assertions.sv
// Port checker for the counter array value registers
module cavr_regs_assertions
    import cavr_pkg::*;
#(
    parameter int NUM_MOD = 3
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic [NUM_MOD-1:0] comparator_enable,
    input wire logic [NUM_MOD-1:0] match,
    input wire logic [15:0] counter_value
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Shadow of the control byte, so lock and run are known here
    logic [7:0] ctrl_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) ctrl_q <= 8'h00;
        else if (wr_en && addr == 8'he0) ctrl_q <= wdata;
    end
    idle_read_a: assert property (!rd_en |=> rdata == 8'h00) else $error("rdata not idle");
    low_read_a: assert property (rd_en && addr == 8'hf9 |=> rdata == counter_value[7:0])
        else $error("low read wrong");
    snap_read_a: assert property (rd_en && addr == 8'hf9 ##1 rd_en && addr == 8'hfa
        |=> rdata == $past(counter_value[15:8])) else $error("snapshot wrong");
    ecom_clear_a: assert property (wr_en && addr == 8'hfb |-> ##2 !comparator_enable[0])
        else $error("enable 0 not cleared");
    ecom_set_a: assert property (wr_en && addr == 8'hea |-> ##2 comparator_enable[1])
        else $error("enable 1 not set");
    ecom_two_a: assert property (wr_en && addr == 8'heb |-> ##2 !comparator_enable[2])
        else $error("enable 2 not cleared");
    // Run held off, so a refused write must leave the count frozen
    cnt_lock_a: assert property (wr_en && (addr == 8'hf9 || addr == 8'hfa) && ctrl_q[2:1] == 2'b01
        |-> ##2 $stable(counter_value)) else $error("locked write landed");
    cnt_write_a: assert property (wr_en && addr == 8'hfa && ctrl_q[2:1] == 2'b00
        |-> ##2 counter_value[15:8] == $past(wdata, 2)) else $error("high write lost");
    match_gate_a: assert property ((match & ~comparator_enable) == '0) else $error("match while off");
    cover property (rd_en && addr == 8'hf9 ##1 rd_en && addr == 8'hfa);
    cover property (|match);
    cover property (wr_en && addr == 8'hfa && ctrl_q[1]);
endmodule // cavr_regs_assertions

bind cavr_regs cavr_regs_assertions #(.NUM_MOD(NUM_MOD)) u_chk (.clock, .reset, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .comparator_enable, .match, .counter_value);

// ### verification/testbench.sv
// Self-checking bench for the counter array value registers
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic [2:0] comparator_enable;
    logic [2:0] match;
    logic [15:0] counter_value;
    int n_fail = 0;
    int checks = 0;
    // Low and high addresses of modules 0..2
    logic [7:0] lo_a [3] = '{8'hfb, 8'he9, 8'heb};
    logic [7:0] hi_a [3] = '{8'hfc, 8'hea, 8'hec};
    cavr_regs #(.NUM_MOD(3)) dut (.clock, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .comparator_enable, .match, .counter_value);
    always #12.5 clock = ~clock;
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // Read, then judge data in the one cycle it stands
    task automatic rc(logic [7:0] a, logic [7:0] e);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, rdata);
    endtask
    // Enable copy lags the write by one cycle
    task automatic ce(logic [2:0] e);
        @(posedge clock);
        #1 chk("enable", {5'h00, e}, {5'h00, comparator_enable});
    endtask
    task automatic t_reset();
        foreach (lo_a[i]) begin
            rc(lo_a[i], 8'h00);
            rc(hi_a[i], 8'h00);
        end
        rc(8'hfa, 8'h00);
    endtask
    task automatic t_mod();
        logic [2:0] e = 3'b000;
        foreach (lo_a[i]) begin
            wr(8'he0, 8'h00);
            wr(hi_a[i], 8'h10 + 8'(i));
            e[i] = 1'b1;
            ce(e);
            wr(lo_a[i], 8'h20 + 8'(i));
            e[i] = 1'b0;
            ce(e);
            wr(8'he0, 8'h01);
            wr(lo_a[i], 8'h30 + 8'(i));
            wr(hi_a[i], 8'h40 + 8'(i));
            e[i] = 1'b1;
            ce(e);
            rc(lo_a[i], 8'h30 + 8'(i));
            rc(hi_a[i], 8'h40 + 8'(i));
            wr(8'he0, 8'h00);
            rc(lo_a[i], 8'h20 + 8'(i));
            rc(hi_a[i], 8'h10 + 8'(i));
        end
        // Unmapped place reads back zero
        wr(8'h10, 8'h5a);
        rc(8'h10, 8'h00);
    endtask
    // Counter stopped throughout, so every value is exact
    task automatic t_cnt();
        wr(8'he0, 8'h00);
        wr(8'hf9, 8'h34);
        wr(8'hfa, 8'h12);
        rc(8'hf9, 8'h34);
        rc(8'hfa, 8'h12);
        wr(8'he0, 8'h02);
        wr(8'hf9, 8'h66);
        wr(8'hfa, 8'h55);
        wr(8'he0, 8'h00);
        rc(8'hf9, 8'h34);
        rc(8'hfa, 8'h12);
        wr(8'hfa, 8'h77);
        rc(8'hfa, 8'h12);
        rc(8'hf9, 8'h34);
        rc(8'hfa, 8'h77);
    endtask
    task automatic t_match();
        wr(8'hfa, 8'h12);
        wr(8'hfb, 8'h34);
        wr(8'hfc, 8'h12);
        ce(3'b111);
        chk("match", 8'h01, {5'h00, match});
        wr(8'hfb, 8'h34);
        ce(3'b110);
        chk("match", 8'h00, {5'h00, match});
        // Control readback shows the enables in bits 6:4
        rc(8'he0, 8'h60);
    endtask
    // Back-to-back low then high read while counting
    task automatic t_run();
        wr(8'he0, 8'h04);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= 8'hf9;
        @(posedge clock);
        addr <= 8'hfa;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk("snapshot", 8'h12, rdata);
        wr(8'he0, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_mod();
        t_cnt();
        t_match();
        t_run();
        end_of_test();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #100us;
        n_fail++;
        end_of_test();
    end
endmodule // testbench
